// ### hw/spb_pkg.sv
/*
 * Shared constants for the segmented packet bus of the 100G MAC.
 * Assumes a single core clock and an asynchronous active-low reset.
 */
package spb_pkg;
   localparam int SEG_CNT = 4;
   localparam int SEG_W = 128;
   localparam int MTY_W = 4;
   localparam int BUS_W = SEG_CNT * SEG_W;
   // Low empty-count bits that an errored final transfer forces to zero
   localparam int MTY_LOW_W = 3;
   localparam logic [MTY_LOW_W-1:0] MTY_LOW_ZERO = 3'h0;
   localparam logic [MTY_W-1:0] MTY_RST = 4'h0;
   localparam logic [SEG_W-1:0] DATA_RST = 128'h0;
   localparam logic [SEG_CNT-1:0] QUAL_RST = 4'h0;
   // Time from a line-side request to the registered ready output
   localparam int READY_LAT = 1;
endpackage

// ### hw/spb_seg.sv
/*
 * One 128-bit segment stage: captures a segment when its valid is high
 * and masks qualifiers that carry no meaning.
 * Assumes inputs synchronous to mclk; the caller supplies the valid.
 */
`timescale 1ns/1ps
module spb_seg (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic in_valid,
   input wire logic in_begin,
   input wire logic in_finish,
   input wire logic in_err,
   input wire logic [spb_pkg::MTY_W-1:0] in_mty,
   input wire logic [spb_pkg::SEG_W-1:0] in_data,
   output logic out_valid,
   output logic out_begin,
   output logic out_finish,
   output logic out_err,
   output logic [spb_pkg::MTY_W-1:0] out_mty,
   output logic [spb_pkg::SEG_W-1:0] out_data
);

   ////////////////////////////////////////////////////////////////////////
   // Qualifier decode

   wire logic last_w;
   wire logic bad_w;
   wire logic [spb_pkg::MTY_W-1:0] mty_w;

   // Error and empty count only count on the final valid transfer
   assign last_w = in_valid & in_finish; // RULE7 RULE8 RULE14
   assign bad_w = last_w & in_err; // RULE7 RULE13
   // Errored final transfer: low empty bits read as zero, top bit kept
   assign mty_w = !last_w ? spb_pkg::MTY_RST :
                  bad_w ? {in_mty[spb_pkg::MTY_W-1],
                           spb_pkg::MTY_LOW_ZERO} :
                  in_mty; // RULE9 RULE15 RULE19

   ////////////////////////////////////////////////////////////////////////
   // Registers

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_valid <= 1'b0;
         out_begin <= 1'b0;
         out_finish <= 1'b0;
         out_err <= 1'b0;
         out_mty <= spb_pkg::MTY_RST;
      end
      else
      begin
         out_valid <= in_valid; // RULE21
         out_begin <= in_valid & in_begin; // RULE4 RULE11
         out_finish <= last_w; // RULE4 RULE12
         out_err <= bad_w;
         out_mty <= mty_w;
      end
   end

   // Data held between transfers, so it only moves on a captured cycle
   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
         out_data <= spb_pkg::DATA_RST;
      else if (in_valid)
         out_data <= in_data; // RULE3 RULE18
   end

endmodule

// ### hw/spb_mac_top.sv
/*
 * Segmented packet bus of a 100G MAC: four-segment transmit capture
 * toward the line framer and four-segment receive delivery to the user.
 * Assumes the line side presents receive segments already aligned and
 * accepts the registered transmit stream with a drop mark per packet.
 */
// Overview of operation
// RULE1 - Bus is 512 bits as four independent 128-bit segments.
// RULE2 - Each segment has data, valid, begin, finish, error, 4-bit empty.
// RULE3 - Transmit segment data captured only when its valid is high.
// RULE4 - All transmit signals ignored while the segment valid is low.
// RULE5 - User raises begin only on a packet's first transfer.
// RULE6 - User raises finish only on a packet's last transfer.
// RULE7 - Transmit error marks packet bad, sampled only with valid and finish.
// RULE8 - Transmit empty count sampled only with valid and finish.
// RULE9 - Errored finish: low three empty bits treated as zero.
// RULE10 - Receive data meaningful only while receive valid is high.
// RULE11 - Receive begin high on first transfer of each packet.
// RULE12 - Receive finish high on final transfer of each packet.
// RULE13 - Receive error on final transfer shows bad or good packet.
// RULE14 - Receive empty count given on final transfer only.
// RULE15 - Receive error with valid forces low three empty bits zero.
// RULE16 - Transmit packets go to framing; line streams become packets.
// RULE17 - Segment 0 active in any data cycle; first bit at its top.
// RULE18 - First byte in bits 127 to 120, then lower lanes.
// RULE19 - Empty count N: N lowest byte lanes invalid.
// RULE20 - User always accepts receive data; no receive back-pressure.
// RULE21 - All segments sampled and driven on the one core clock edge.
`timescale 1ns/1ps
module spb_mac_top (
   input wire logic mclk,
   input wire logic rst_b,
   // User transmit side, segment 0 in the top 128 bits
   input wire logic [spb_pkg::BUS_W-1:0] tx_data,
   input wire logic [spb_pkg::SEG_CNT-1:0] tx_valid,
   input wire logic [spb_pkg::SEG_CNT-1:0] tx_packet_begin,
   input wire logic [spb_pkg::SEG_CNT-1:0] tx_packet_finish,
   input wire logic [spb_pkg::SEG_CNT-1:0] tx_err,
   input wire logic [spb_pkg::SEG_CNT*spb_pkg::MTY_W-1:0] tx_mty,
   output logic tx_ready,
   output logic tx_order_fault,
   // Line transmit side, toward the framer
   input wire logic line_tx_ready,
   output logic [spb_pkg::BUS_W-1:0] line_tx_data,
   output logic [spb_pkg::SEG_CNT-1:0] line_tx_valid,
   output logic [spb_pkg::SEG_CNT-1:0] line_tx_packet_begin,
   output logic [spb_pkg::SEG_CNT-1:0] line_tx_packet_finish,
   output logic [spb_pkg::SEG_CNT-1:0] line_tx_drop,
   output logic [spb_pkg::SEG_CNT*spb_pkg::MTY_W-1:0] line_tx_mty,
   // Line receive side, from the deframer
   input wire logic [spb_pkg::BUS_W-1:0] line_rx_data,
   input wire logic [spb_pkg::SEG_CNT-1:0] line_rx_valid,
   input wire logic [spb_pkg::SEG_CNT-1:0] line_rx_packet_begin,
   input wire logic [spb_pkg::SEG_CNT-1:0] line_rx_packet_finish,
   input wire logic [spb_pkg::SEG_CNT-1:0] line_rx_bad,
   input wire logic [spb_pkg::SEG_CNT*spb_pkg::MTY_W-1:0] line_rx_mty,
   // User receive side
   output logic [spb_pkg::BUS_W-1:0] rx_data,
   output logic [spb_pkg::SEG_CNT-1:0] rx_valid,
   output logic [spb_pkg::SEG_CNT-1:0] rx_packet_begin,
   output logic [spb_pkg::SEG_CNT-1:0] rx_packet_finish,
   output logic [spb_pkg::SEG_CNT-1:0] rx_err,
   output logic [spb_pkg::SEG_CNT*spb_pkg::MTY_W-1:0] rx_mty
);

   ////////////////////////////////////////////////////////////////////////
   // Segment stages, transmit and receive

   // Segment i sits below segment i-1, so segment 0 owns the MSBs
   genvar g;
   generate
      for (g = 0; g < spb_pkg::SEG_CNT; g++)
      begin : seg
         localparam int DH = spb_pkg::BUS_W - 1 - g * spb_pkg::SEG_W;
         localparam int MH = (spb_pkg::SEG_CNT - g) * spb_pkg::MTY_W - 1;
         localparam int S = spb_pkg::SEG_CNT - 1 - g;
         spb_seg u_tx (
            .mclk(mclk),
            .rst_b(rst_b),
            .in_valid(tx_valid[S]),
            .in_begin(tx_packet_begin[S]),
            .in_finish(tx_packet_finish[S]),
            .in_err(tx_err[S]),
            .in_mty(tx_mty[MH -: spb_pkg::MTY_W]),
            .in_data(tx_data[DH -: spb_pkg::SEG_W]),
            .out_valid(line_tx_valid[S]),
            .out_begin(line_tx_packet_begin[S]),
            .out_finish(line_tx_packet_finish[S]),
            .out_err(line_tx_drop[S]),
            .out_mty(line_tx_mty[MH -: spb_pkg::MTY_W]),
            .out_data(line_tx_data[DH -: spb_pkg::SEG_W])
         ); // RULE1 RULE2 RULE16 RULE17
         spb_seg u_rx (
            .mclk(mclk),
            .rst_b(rst_b),
            .in_valid(line_rx_valid[S]),
            .in_begin(line_rx_packet_begin[S]),
            .in_finish(line_rx_packet_finish[S]),
            .in_err(line_rx_bad[S]),
            .in_mty(line_rx_mty[MH -: spb_pkg::MTY_W]),
            .in_data(line_rx_data[DH -: spb_pkg::SEG_W]),
            .out_valid(rx_valid[S]),
            .out_begin(rx_packet_begin[S]),
            .out_finish(rx_packet_finish[S]),
            .out_err(rx_err[S]),
            .out_mty(rx_mty[MH -: spb_pkg::MTY_W]),
            .out_data(rx_data[DH -: spb_pkg::SEG_W])
         ); // RULE1 RULE2 RULE10 RULE16 RULE20
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Transmit packet order check

   // Segment S = SEG_CNT-1-g carries segment number g; bit 3 is segment 0
   function automatic logic seg_bit(input logic [spb_pkg::SEG_CNT-1:0] v,
                                    input int n);
      seg_bit = v[spb_pkg::SEG_CNT - 1 - n];
   endfunction

   logic in_pkt_q;
   logic in_pkt_d;
   logic fault_d;
   logic fault_q;
   logic ready_q;

   // Walks the four segments in transfer order; a begin inside a packet,
   // data outside one or a gap between active segments is a fault
   always_comb
   begin
      logic run;
      logic flt;
      run = in_pkt_q;
      flt = 1'b0;
      for (int n = 0; n < spb_pkg::SEG_CNT; n++)
      begin
         if (seg_bit(tx_valid, n))
         begin
            if (n > 0 && !seg_bit(tx_valid, n - 1))
               flt = 1'b1; // RULE17
            if (seg_bit(tx_packet_begin, n) == run)
               flt = 1'b1; // RULE5
            run = ~seg_bit(tx_packet_finish, n); // RULE6
         end
      end
      in_pkt_d = run;
      fault_d = flt;
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         in_pkt_q <= 1'b0;
         fault_q <= 1'b0;
         ready_q <= 1'b0;
      end
      else
      begin
         in_pkt_q <= in_pkt_d;
         fault_q <= fault_d;
         // Registered so the ready output comes straight from a flop
         ready_q <= line_tx_ready;
      end
   end

   assign tx_ready = ready_q;
   assign tx_order_fault = fault_q;

   ////////////////////////////////////////////////////////////////////////
   // Checks

   property p_tx_capture;
      @(posedge mclk) disable iff (!rst_b)
      tx_valid[3] |=> line_tx_valid[3] &&
         line_tx_data[511:384] == $past(tx_data[511:384]);
   endproperty
   a_tx_capture: assert property (p_tx_capture) // RULE3
      else $error("Transmit segment 0 not captured");

   property p_tx_ignore;
      @(posedge mclk) disable iff (!rst_b)
      !tx_valid[2] |=> !line_tx_valid[2] && !line_tx_packet_begin[2] &&
         $stable(line_tx_data[383:256]);
   endproperty
   a_tx_ignore: assert property (p_tx_ignore) // RULE4
      else $error("Transmit segment 1 moved while not valid");

   property p_tx_err_mty;
      @(posedge mclk) disable iff (!rst_b)
      tx_valid[3] && tx_packet_finish[3] && tx_err[3] |=>
         line_tx_drop[3] && line_tx_mty[14:12] == 3'h0 &&
         line_tx_mty[15] == $past(tx_mty[15]);
   endproperty
   a_tx_err_mty: assert property (p_tx_err_mty) // RULE9
      else $error("Errored finish empty count not masked");

   property p_tx_err_gate;
      @(posedge mclk) disable iff (!rst_b)
      tx_err[1] && !(tx_valid[1] && tx_packet_finish[1]) |=>
         !line_tx_drop[1];
   endproperty
   a_tx_err_gate: assert property (p_tx_err_gate) // RULE7
      else $error("Transmit error taken outside a finish");

   property p_tx_mty;
      @(posedge mclk) disable iff (!rst_b)
      tx_valid[0] && tx_packet_finish[0] && !tx_err[0] |=>
         line_tx_mty[3:0] == $past(tx_mty[3:0]);
   endproperty
   a_tx_mty: assert property (p_tx_mty) // RULE8
      else $error("Transmit empty count not passed");

   property p_rx_valid;
      @(posedge mclk) disable iff (!rst_b)
      line_rx_valid[3] |=> rx_valid[3] &&
         rx_data[511:384] == $past(line_rx_data[511:384]);
   endproperty
   a_rx_valid: assert property (p_rx_valid) // RULE10
      else $error("Receive segment 0 not delivered");

   property p_rx_mty_zero;
      @(posedge mclk) disable iff (!rst_b)
      rx_err[2] && rx_valid[2] |-> rx_mty[10:8] == 3'h0;
   endproperty
   a_rx_mty_zero: assert property (p_rx_mty_zero) // RULE15
      else $error("Receive error with nonzero low empty bits");

   property p_rx_begin;
      @(posedge mclk) disable iff (!rst_b)
      line_rx_valid[1] && line_rx_packet_begin[1] |=> rx_packet_begin[1];
   endproperty
   a_rx_begin: assert property (p_rx_begin) // RULE11
      else $error("Receive begin lost");

   property p_rx_finish;
      @(posedge mclk) disable iff (!rst_b)
      rx_packet_finish[0] |-> rx_valid[0];
   endproperty
   a_rx_finish: assert property (p_rx_finish) // RULE12
      else $error("Receive finish without valid");

   property p_rx_err;
      @(posedge mclk) disable iff (!rst_b)
      line_rx_valid[3] && line_rx_packet_finish[3] |=>
         rx_err[3] == $past(line_rx_bad[3]) && rx_packet_finish[3];
   endproperty
   a_rx_err: assert property (p_rx_err) // RULE13 RULE14
      else $error("Receive error not reported on finish");

endmodule

// ### bench/spb_user_model.sv
/*
 * User-logic partner: packet source on the transmit segments and an
 * always-ready sink on the receive segments.
 * Assumes one bench process calls send, starting between clock edges.
 */
`timescale 1ns/1ps
module spb_user_model (
   input wire logic mclk,
   input wire logic [3:0] rx_valid,
   input wire logic [3:0] rx_packet_finish,
   output logic [511:0] tx_data,
   output logic [3:0] tx_valid,
   output logic [3:0] tx_packet_begin,
   output logic [3:0] tx_packet_finish,
   output logic [3:0] tx_err,
   output logic [15:0] tx_mty,
   output int rx_pkts
);
   initial
   begin
      tx_data = 512'h0;
      tx_valid = 4'h0;
      tx_packet_begin = 4'hf;
      tx_packet_finish = 4'hf;
      tx_err = 4'hf;
      tx_mty = 16'hffff;
      rx_pkts = 0;
   end

   ////////////////////////////////////////////////////////////////////////
   // Idle segments carry flipped data and junk flags, never a clean copy
   task automatic send(input logic [3:0] v, b, f, e,
      input logic [15:0] m, input logic [511:0] d);
      @(negedge mclk);
      for (int i = 0; i < 4; i++)
      begin
         tx_data[i*128+:128] = v[i] ? d[i*128+:128] : ~tx_data[i*128+:128];
         tx_mty[i*4+:4] = v[i] ? m[i*4+:4] : 4'hf;
      end
      tx_valid = v;
      tx_packet_begin = b | ~v;
      tx_packet_finish = f | ~v;
      // Error stays low on valid non-final transfers, junk on idle ones
      tx_err = (e & f & v) | ~v;
      @(posedge mclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   // No stall path exists, so every finished packet is counted at once
   always @(posedge mclk)
      rx_pkts <= rx_pkts + $countones(rx_valid & rx_packet_finish);
endmodule

// ### bench/spb_testbench.sv
/*
 * Self-checking bench for the segmented packet bus block.
 * Assumes the partner model drives the user transmit side.
 */
`timescale 1ns/1ps
module testbench;
   localparam logic [511:0] D1 = {128'h00112233445566778899aabbccddeeff,
      128'h1, 128'h22, 128'h333};
   localparam logic [511:0] D2 = ~D1;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic line_tx_ready = 1'b0;
   logic [511:0] line_rx_data = 512'h0;
   logic [3:0] line_rx_valid = 4'h0;
   logic [3:0] line_rx_packet_begin = 4'h0;
   logic [3:0] line_rx_packet_finish = 4'h0;
   logic [3:0] line_rx_bad = 4'h0;
   logic [15:0] line_rx_mty = 16'h0;
   logic [511:0] tx_data, line_tx_data, rx_data;
   logic [511:0] exp_t = 512'h0;
   logic [511:0] exp_r = 512'h0;
   logic [3:0] tx_valid, tx_packet_begin, tx_packet_finish, tx_err;
   logic [3:0] line_tx_valid, line_tx_packet_begin, line_tx_packet_finish;
   logic [3:0] line_tx_drop, rx_valid, rx_packet_begin, rx_packet_finish;
   logic [3:0] rx_err;
   logic [15:0] tx_mty, line_tx_mty, rx_mty;
   logic tx_ready, tx_order_fault;
   int rx_pkts;
   int fail_count = 0;
   int num_checks = 0;
   int cycles = 0;

   always #4 mclk = ~mclk;

   spb_mac_top dut (
      .mclk, .rst_b, .tx_data, .tx_valid, .tx_packet_begin,
      .tx_packet_finish, .tx_err, .tx_mty, .tx_ready, .tx_order_fault,
      .line_tx_ready, .line_tx_data, .line_tx_valid, .line_tx_packet_begin,
      .line_tx_packet_finish, .line_tx_drop, .line_tx_mty, .line_rx_data,
      .line_rx_valid, .line_rx_packet_begin, .line_rx_packet_finish,
      .line_rx_bad, .line_rx_mty, .rx_data, .rx_valid, .rx_packet_begin,
      .rx_packet_finish, .rx_err, .rx_mty
   );

   spb_user_model u_user (
      .mclk, .rx_valid, .rx_packet_finish, .tx_data, .tx_valid,
      .tx_packet_begin, .tx_packet_finish, .tx_err, .tx_mty, .rx_pkts
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic chk_d(input logic [511:0] got, input logic [511:0] exp);
      num_checks++;
      if (got !== exp)
         $display("Error at %0t: data %h, expected %h", $time, got, exp);
      if (got !== exp)
         fail_count++;
   endtask

   task automatic chk_f(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
         $display("Error at %0t: flags %h, expected %h", $time, got, exp);
      if (got !== exp)
         fail_count++;
   endtask

   // Also serves to mask a got value: pass zero error bits
   function automatic logic [15:0] emty(input logic [15:0] m,
      input logic [3:0] k, input logic [3:0] e);
      logic [15:0] r;
      r = 16'h0;
      for (int i = 0; i < 4; i++)
         if (k[i])
            r[i*4+:4] = e[i] ? {m[i*4+3], 3'h0} : m[i*4+:4];
      return r;
   endfunction

   function automatic logic [511:0] merge(input logic [511:0] o, n,
      input logic [3:0] v);
      for (int i = 0; i < 4; i++)
         if (v[i])
            o[i*128+:128] = n[i*128+:128];
      return o;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   task automatic tx_cycle(input logic [3:0] v, b, f, e,
      input logic [15:0] m, input logic [511:0] d, input logic fe);
      u_user.send(v, b, f, e, m, d);
      #1;
      exp_t = merge(exp_t, d, v);
      chk_d(line_tx_data, exp_t);
      chk_f({line_tx_valid, line_tx_packet_begin, line_tx_packet_finish,
         line_tx_drop, line_tx_mty},
         {v, b & v, f & v, e & f & v, emty(m, v & f, e)});
      chk_f({31'h0, tx_order_fault}, {31'h0, fe});
   endtask

   task automatic rx_cycle(input logic [3:0] v, b, f, e,
      input logic [15:0] m, input logic [511:0] d);
      @(negedge mclk);
      for (int i = 0; i < 4; i++)
         line_rx_data[i*128+:128] = v[i] ? d[i*128+:128]
            : ~line_rx_data[i*128+:128];
      line_rx_valid = v;
      line_rx_packet_begin = b | ~v;
      line_rx_packet_finish = f | ~v;
      line_rx_bad = e | ~v;
      line_rx_mty = m;
      @(posedge mclk);
      #1;
      exp_r = merge(exp_r, d, v);
      chk_d(rx_data, exp_r);
      chk_f({rx_valid, rx_packet_begin & rx_valid,
         rx_packet_finish & rx_valid, rx_err & rx_valid & rx_packet_finish,
         emty(rx_mty, rx_valid & rx_packet_finish, 4'h0)},
         {v, b & v, f & v, e & f & v, emty(m, v & f, e)});
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic t_tx;
      tx_cycle(4'hf, 4'h8, 4'h0, 4'h0, 16'h0, D1, 1'b0);
      tx_cycle(4'hc, 4'h0, 4'h4, 4'h0, 16'h0500, D2, 1'b0);
      tx_cycle(4'hf, 4'hf, 4'hf, 4'hc, 16'h9d37, D1, 1'b0);
      tx_cycle(4'h0, 4'h0, 4'h0, 4'h0, 16'h0, D2, 1'b0);
      tx_cycle(4'ha, 4'ha, 4'ha, 4'h0, 16'h0, D2, 1'b1);
      tx_cycle(4'h0, 4'h0, 4'h0, 4'h0, 16'h0, D1, 1'b0);
      // Deliberate order faults: data outside a packet, then begin inside
      tx_cycle(4'h8, 4'h0, 4'h0, 4'h0, 16'h0, D2, 1'b1);
      tx_cycle(4'h8, 4'h8, 4'h8, 4'h0, 16'h0, D1, 1'b1);
   endtask

   task automatic t_ready;
      @(negedge mclk);
      line_tx_ready = 1'b1;
      @(posedge mclk);
      #1;
      chk_f({31'h0, tx_ready}, 32'h1);
      @(negedge mclk);
      line_tx_ready = 1'b0;
      @(posedge mclk);
      #1;
      chk_f({31'h0, tx_ready}, 32'h0);
   endtask

   task automatic t_rx;
      rx_cycle(4'he, 4'h8, 4'h2, 4'h2, 16'h00d0, D2);
      rx_cycle(4'hf, 4'hf, 4'hf, 4'h5, 16'h1234, D1);
      rx_cycle(4'h0, 4'h0, 4'h0, 4'h0, 16'hffff, D2);
      chk_f(32'(rx_pkts), 32'h5);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("Checks %0d, errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Whole run is about 24 cycles; the ceiling leaves wide margin
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 500)
      begin
         fail_count++;
         wrap_up();
      end
   end

   initial
   begin
      repeat (10) @(negedge mclk);
      rst_b = 1'b1;
      @(posedge mclk);
      #1;
      chk_f({line_tx_valid, line_tx_drop, rx_valid, rx_err, 16'h0}, 32'h0);
      t_tx();
      t_ready();
      t_rx();
      wrap_up();
   end
endmodule
